/* src/cbs_op_classifier.sv */
// Opcode classifier giving instruction class and cycle count
module cbs_op_classifier (
    input wire logic [7:0] i_opcode,
    output logic [3:0] o_cls,
    output logic [2:0] o_len
);

    // Class from upper nibble; unknown codes become one-cycle fetches
    always_comb begin
        o_cls = cbs_pkg::CLS_NONE;
        o_len = cbs_pkg::LEN_NONE;
        case (i_opcode[7:4])
            cbs_pkg::CLS_IMM8: begin
                o_cls = cbs_pkg::CLS_IMM8;
                o_len = cbs_pkg::LEN_IMM8;
            end
            cbs_pkg::CLS_IMM16_LD: begin
                o_cls = cbs_pkg::CLS_IMM16_LD;
                o_len = cbs_pkg::LEN_IMM16_LD;
            end
            cbs_pkg::CLS_IMM16_AR: begin
                o_cls = cbs_pkg::CLS_IMM16_AR;
                o_len = cbs_pkg::LEN_IMM16_AR;
            end
            cbs_pkg::CLS_DIR8: begin
                o_cls = cbs_pkg::CLS_DIR8;
                o_len = cbs_pkg::LEN_DIR8;
            end
            cbs_pkg::CLS_DIR_STA: begin
                o_cls = cbs_pkg::CLS_DIR_STA;
                o_len = cbs_pkg::LEN_DIR8;
            end
            cbs_pkg::CLS_DIR16_LD: begin
                o_cls = cbs_pkg::CLS_DIR16_LD;
                o_len = cbs_pkg::LEN_DIR16;
            end
            cbs_pkg::CLS_DIR16_ST: begin
                o_cls = cbs_pkg::CLS_DIR16_ST;
                o_len = cbs_pkg::LEN_DIR16;
            end
            cbs_pkg::CLS_DIR16_AR: begin
                o_cls = cbs_pkg::CLS_DIR16_AR;
                o_len = cbs_pkg::LEN_DIR16_AR;
            end
            cbs_pkg::CLS_DIR_JSR: begin
                o_cls = cbs_pkg::CLS_DIR_JSR;
                o_len = cbs_pkg::LEN_JSR;
            end
            default: begin
                o_cls = cbs_pkg::CLS_NONE;
                o_len = cbs_pkg::LEN_NONE;
            end
        endcase
    end

endmodule

/* src/cbs_pkg.sv */
// Package of constants and types for the bus-cycle sequencer
package cbs_pkg;

    // Reset, vector, page, on-chip window, mode and step constants
    localparam logic [15:0] RESET_PC = 16'h0000;
    localparam logic [15:0] VEC_ADDR = 16'hFFFF;
    localparam logic [7:0] DIR_PAGE = 8'h00;
    localparam logic [15:0] INT_TOP = 16'h00FF;
    localparam logic [2:0] MODE_ZERO = 3'h0;
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_TWO = 16'h0002;
    localparam logic [15:0] STEP_THREE = 16'h0003;

    // Instruction classes, taken from the opcode's upper nibble
    localparam logic [3:0] CLS_NONE = 4'h0;
    localparam logic [3:0] CLS_IMM8 = 4'h1;
    localparam logic [3:0] CLS_IMM16_LD = 4'h2;
    localparam logic [3:0] CLS_IMM16_AR = 4'h3;
    localparam logic [3:0] CLS_DIR8 = 4'h4;
    localparam logic [3:0] CLS_DIR_STA = 4'h5;
    localparam logic [3:0] CLS_DIR16_LD = 4'h6;
    localparam logic [3:0] CLS_DIR16_ST = 4'h7;
    localparam logic [3:0] CLS_DIR16_AR = 4'h8;
    localparam logic [3:0] CLS_DIR_JSR = 4'h9;

    // Cycle counts per class
    localparam logic [2:0] LEN_NONE = 3'h1;
    localparam logic [2:0] LEN_IMM8 = 3'h2;
    localparam logic [2:0] LEN_IMM16_LD = 3'h3;
    localparam logic [2:0] LEN_IMM16_AR = 3'h4;
    localparam logic [2:0] LEN_DIR8 = 3'h3;
    localparam logic [2:0] LEN_DIR16 = 3'h4;
    localparam logic [2:0] LEN_DIR16_AR = 3'h5;
    localparam logic [2:0] LEN_JSR = 3'h5;

    // One-hot cycle states
    typedef enum logic [4:0] {
        CBS_C1 = 5'b00001,
        CBS_C2 = 5'b00010,
        CBS_C3 = 5'b00100,
        CBS_C4 = 5'b01000,
        CBS_C5 = 5'b10000
    } cbs_state_e;

    // Address falls inside the on-chip window
    function automatic logic cbs_is_internal(input logic [15:0] addr);
        cbs_is_internal = (addr <= INT_TOP);
    endfunction

    // Direct-page address from a fetched byte
    function automatic logic [15:0] cbs_dir_addr(input logic [7:0] lo);
        cbs_dir_addr = {DIR_PAGE, lo};
    endfunction

endpackage

/* src/cbs_sequencer.sv */
// Bus-cycle sequencer for immediate and direct instructions
module cbs_sequencer (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_mode,
    input wire logic [7:0] i_data_in,
    input wire logic [7:0] i_int_data,
    input wire logic [15:0] i_sp,
    input wire logic [7:0] i_acc,
    input wire logic [15:0] i_word,
    output logic [15:0] o_addr,
    output logic o_rw,
    output logic [7:0] o_data_out,
    output logic o_data_oe_n,
    output logic o_sync,
    output logic o_done,
    output logic o_sp_dec2,
    output logic [7:0] o_opcode,
    output logic [15:0] o_operand
);

    cbs_pkg::cbs_state_e state_reg, state_next;
    logic [15:0] pc_reg, pc_next;
    logic [7:0] opc_reg, opc_next;
    logic [7:0] dir_reg, dir_next;
    logic [15:0] opd_reg, opd_next;
    logic [15:0] addr_reg, addr_next;
    logic rw_reg, rw_next;
    logic [7:0] dout_reg, dout_next;
    logic [7:0] rd_data;
    logic [7:0] cls_opcode;
    logic [3:0] cls_now;
    logic [2:0] len_now;
    logic [2:0] idx_now, idx_next;
    logic last;
    logic [15:0] dir_word;
    logic [15:0] ret_addr;
    logic show_int;
    logic [2:0] mode_s1_reg, mode_s2_reg, mode_s3_reg;
    logic [2:0] mode_reg, mode_next;

    // Cycle index 1..5 from the one-hot state
    function automatic logic [2:0] state_idx(input cbs_pkg::cbs_state_e st);
        case (st)
            cbs_pkg::CBS_C1: state_idx = 3'h1;
            cbs_pkg::CBS_C2: state_idx = 3'h2;
            cbs_pkg::CBS_C3: state_idx = 3'h3;
            cbs_pkg::CBS_C4: state_idx = 3'h4;
            cbs_pkg::CBS_C5: state_idx = 3'h5;
            default: state_idx = 3'h1;
        endcase
    endfunction

    // On-chip reads use the internal value, not the pins
    assign rd_data = cbs_pkg::cbs_is_internal(addr_reg) ? i_int_data : i_data_in;

    // Class comes from the byte arriving in the fetch cycle, then from the latch
    assign cls_opcode = (state_reg == cbs_pkg::CBS_C1) ? rd_data : opc_reg;

    cbs_op_classifier u_classifier (
        .i_opcode(cls_opcode),
        .o_cls(cls_now),
        .o_len(len_now)
    );

    assign idx_now = state_idx(state_reg);
    assign last = (idx_now == len_now);
    assign ret_addr = pc_reg + cbs_pkg::STEP_TWO;

    // Direct operand address; in cycle two the byte is still on the bus
    assign dir_word = cbs_pkg::cbs_dir_addr(dir_next);

    // Sequencing, latches and next-cycle index; same class, same sequence
    always_comb begin
        state_next = state_reg;
        pc_next = pc_reg;
        opc_next = opc_reg;
        dir_next = dir_reg;
        opd_next = opd_reg;
        idx_next = 3'h1;
        if (state_reg == cbs_pkg::CBS_C1) begin
            opc_next = rd_data;
        end
        if (state_reg == cbs_pkg::CBS_C2) begin
            dir_next = rd_data;
        end
        // Operand capture, high byte into the upper half
        case (cls_now)
            cbs_pkg::CLS_IMM8: begin
                if (idx_now == 3'h2) opd_next = {8'h00, rd_data};
            end
            cbs_pkg::CLS_IMM16_LD, cbs_pkg::CLS_IMM16_AR: begin
                if (idx_now == 3'h2) opd_next[15:8] = rd_data;
                if (idx_now == 3'h3) opd_next[7:0] = rd_data;
            end
            cbs_pkg::CLS_DIR8: begin
                if (idx_now == 3'h3) opd_next = {8'h00, rd_data};
            end
            cbs_pkg::CLS_DIR16_LD, cbs_pkg::CLS_DIR16_AR: begin
                if (idx_now == 3'h3) opd_next[15:8] = rd_data;
                if (idx_now == 3'h4) opd_next[7:0] = rd_data;
            end
            default: begin
                opd_next = opd_reg;
            end
        endcase
        // Instruction end picks the next opcode address
        if (last) begin
            state_next = cbs_pkg::CBS_C1;
            case (cls_now)
                cbs_pkg::CLS_NONE: pc_next = pc_reg + cbs_pkg::STEP_ONE;
                cbs_pkg::CLS_IMM8: pc_next = pc_reg + cbs_pkg::STEP_TWO;
                cbs_pkg::CLS_IMM16_LD, cbs_pkg::CLS_IMM16_AR: begin
                    pc_next = pc_reg + cbs_pkg::STEP_THREE;
                end
                cbs_pkg::CLS_DIR_JSR: pc_next = cbs_pkg::cbs_dir_addr(dir_reg);
                default: pc_next = pc_reg + cbs_pkg::STEP_TWO;
            endcase
        end else begin
            case (state_reg)
                cbs_pkg::CBS_C1: state_next = cbs_pkg::CBS_C2;
                cbs_pkg::CBS_C2: state_next = cbs_pkg::CBS_C3;
                cbs_pkg::CBS_C3: state_next = cbs_pkg::CBS_C4;
                cbs_pkg::CBS_C4: state_next = cbs_pkg::CBS_C5;
                default: state_next = cbs_pkg::CBS_C1;
            endcase
        end
        idx_next = state_idx(state_next);
    end

    // Bus content of the coming cycle, registered so every cycle is defined
    always_comb begin
        addr_next = pc_next;
        rw_next = 1'b1;
        dout_next = 8'h00;
        case (idx_next)
            3'h1: addr_next = pc_next;
            3'h2: addr_next = pc_reg + cbs_pkg::STEP_ONE;
            3'h3: begin
                if (cls_now == cbs_pkg::CLS_IMM16_LD || cls_now == cbs_pkg::CLS_IMM16_AR) begin
                    addr_next = pc_reg + cbs_pkg::STEP_TWO;
                end else begin
                    addr_next = dir_word;
                end
                if (cls_now == cbs_pkg::CLS_DIR_STA) begin
                    rw_next = 1'b0;
                    dout_next = i_acc;
                end
                if (cls_now == cbs_pkg::CLS_DIR16_ST) begin
                    rw_next = 1'b0;
                    dout_next = i_word[15:8];
                end
            end
            3'h4: begin
                case (cls_now)
                    cbs_pkg::CLS_IMM16_AR: addr_next = cbs_pkg::VEC_ADDR;
                    cbs_pkg::CLS_DIR_JSR: begin
                        addr_next = i_sp;
                        rw_next = 1'b0;
                        dout_next = ret_addr[7:0];
                    end
                    cbs_pkg::CLS_DIR16_ST: begin
                        addr_next = cbs_pkg::cbs_dir_addr(dir_reg) + cbs_pkg::STEP_ONE;
                        rw_next = 1'b0;
                        dout_next = i_word[7:0];
                    end
                    default: addr_next = cbs_pkg::cbs_dir_addr(dir_reg) + cbs_pkg::STEP_ONE;
                endcase
            end
            3'h5: begin
                if (cls_now == cbs_pkg::CLS_DIR_JSR) begin
                    addr_next = i_sp - cbs_pkg::STEP_ONE;
                    rw_next = 1'b0;
                    dout_next = ret_addr[15:8];
                end else begin
                    addr_next = cbs_pkg::VEC_ADDR; // Dummy vector read
                end
            end
            default: addr_next = pc_next;
        endcase
    end

    // Registers only; reset lands on an opcode fetch at the reset address
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= cbs_pkg::CBS_C1;
            pc_reg <= cbs_pkg::RESET_PC;
            opc_reg <= 8'h00;
            dir_reg <= 8'h00;
            opd_reg <= 16'h0000;
            addr_reg <= cbs_pkg::RESET_PC;
            rw_reg <= 1'b1;
            dout_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            pc_reg <= pc_next;
            opc_reg <= opc_next;
            dir_reg <= dir_next;
            opd_reg <= opd_next;
            addr_reg <= addr_next;
            rw_reg <= rw_next;
            dout_reg <= dout_next;
        end
    end

    // Mode pins pass three flops; a new level counts once the last two agree
    always_comb begin
        mode_next = (mode_s2_reg == mode_s3_reg) ? mode_s3_reg : mode_reg;
    end

    // No reset on this chain, so the mode settles while the core is held in reset
    always_ff @(posedge i_clk) begin
        mode_s1_reg <= i_mode;
        mode_s2_reg <= mode_s1_reg;
        mode_s3_reg <= mode_s2_reg;
        mode_reg <= mode_next;
    end

    // Internal reads are mirrored on the pins only in mode zero; this path
    // is combinational because the value exists only in the read cycle
    assign show_int = rw_reg && cbs_pkg::cbs_is_internal(addr_reg)
        && (mode_reg == cbs_pkg::MODE_ZERO);
    assign o_addr = addr_reg;
    assign o_rw = rw_reg;
    assign o_data_out = show_int ? i_int_data : dout_reg;
    assign o_data_oe_n = ~(~rw_reg | show_int);
    assign o_sync = (state_reg == cbs_pkg::CBS_C1);
    assign o_done = last;
    assign o_sp_dec2 = last && (cls_now == cbs_pkg::CLS_DIR_JSR);
    assign o_opcode = opc_reg;
    assign o_operand = opd_reg;

    // Checks on the bus sequence
    property p_write_drives;
        @(posedge i_clk) disable iff (!i_rst_n)
        !o_rw |-> !o_data_oe_n;
    endproperty
    a_write_drives: assert property (p_write_drives) else $error("write without drive");

    property p_imm16_ld;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_done && cls_now == cbs_pkg::CLS_IMM16_LD) |->
            $past(o_sync, 2) && o_rw && o_addr == $past(o_addr, 2) + 16'h0002;
    endproperty
    a_imm16_ld: assert property (p_imm16_ld) else $error("immediate load wrong");

    property p_imm16_ar;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_done && cls_now == cbs_pkg::CLS_IMM16_AR) |->
            $past(o_sync, 3) && o_rw && o_addr == 16'hFFFF;
    endproperty
    a_imm16_ar: assert property (p_imm16_ar) else $error("immediate arith wrong");

    property p_dir16_ld;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_done && cls_now == cbs_pkg::CLS_DIR16_LD) |->
            $past(o_sync, 3) && o_rw && o_addr == $past(o_addr) + 16'h0001;
    endproperty
    a_dir16_ld: assert property (p_dir16_ld) else $error("direct load sequence wrong");

    property p_dir16_st;
        @(posedge i_clk) disable iff (!i_rst_n)
        (idx_now == 3'h3 && cls_now == cbs_pkg::CLS_DIR16_ST) |->
            !o_rw && o_data_out == $past(i_word[15:8])
            ##1 !o_rw && o_done && o_addr == $past(o_addr) + 16'h0001;
    endproperty
    a_dir16_st: assert property (p_dir16_st) else $error("direct store sequence wrong");

    property p_jsr_low;
        @(posedge i_clk) disable iff (!i_rst_n)
        (idx_now == 3'h4 && cls_now == cbs_pkg::CLS_DIR_JSR) |->
            !o_rw && o_addr == $past(i_sp) && o_data_out == ret_addr[7:0];
    endproperty
    a_jsr_low: assert property (p_jsr_low) else $error("call low push wrong");

    property p_jsr_high;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_done && cls_now == cbs_pkg::CLS_DIR_JSR) |->
            !o_rw && o_addr == $past(o_addr) - 16'h0001 && o_data_out == ret_addr[15:8];
    endproperty
    a_jsr_high: assert property (p_jsr_high) else $error("call high push wrong");

    property p_int_hidden;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_rw && cbs_pkg::cbs_is_internal(o_addr) && i_mode != 3'h0) |-> o_data_oe_n;
    endproperty
    a_int_hidden: assert property (p_int_hidden) else $error("internal read exposed");

    property p_imm8;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_done && cls_now == cbs_pkg::CLS_IMM8) |->
            $past(o_sync) && o_rw && o_addr == $past(o_addr) + 16'h0001;
    endproperty
    a_imm8: assert property (p_imm8) else $error("immediate byte sequence wrong");

    property p_sta;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_done && cls_now == cbs_pkg::CLS_DIR_STA) |->
            $past(o_sync, 2) && !o_rw && o_data_out == $past(i_acc);
    endproperty
    a_sta: assert property (p_sta) else $error("accumulator store wrong");

    c_jsr: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_sp_dec2);
    c_store: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        o_done && cls_now == cbs_pkg::CLS_DIR16_ST);
    c_vector: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        o_addr == 16'hFFFF && o_done);
    c_mode0: cover property (@(posedge i_clk) disable iff (!i_rst_n) show_int);

endmodule

/* testbench/cbs_mem_model.sv */
// Memory partner on the expansion bus for the bus-cycle sequencer, zero wait states
module cbs_mem_model (
    input wire logic i_clk,
    input wire logic [15:0] i_addr,
    input wire logic i_rw,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic [7:0] o_int_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [0:65535];
    logic [7:0] last_reg;

    // Fill with a pattern so that no cell ever reads back unknown
    initial begin
        for (int k = 0; k < 65536; k++) begin
            mem[k] = 8'(k) ^ 8'hA5;
        end
        last_reg = 8'h00;
    end

    // On-chip locations are answered at once through the core
    assign o_int_data = mem[i_addr];

    // Deselected or driven-by-device bus shows the inverse of its last value, never a stale copy
    assign o_rdata = (i_rw && i_addr > cbs_pkg::INT_TOP) ? mem[i_addr] : ~last_reg;

    // Writes land at the edge ending the cycle; bus history feeds the released pattern
    always @(posedge i_clk) begin
        if (!i_rw) begin
            mem[i_addr] <= i_wdata;
        end
        last_reg <= o_rdata;
    end
endmodule

/* testbench/cpu_bus_cycle_sequencer_bench.sv */
// Self-checking bench for the bus-cycle sequencer: random programs against expected cycles
module cpu_bus_cycle_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [15:0] a;
        logic rw;
        logic [7:0] wd;
        logic done;
        logic sync;
        logic dec;
        logic opc;
        logic [15:0] opv;
        logic [7:0] op;
    } cbs_exp_s;

    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [2:0] i_mode = 3'h0;
    logic [7:0] i_data_in;
    logic [7:0] i_int_data;
    logic [15:0] i_sp = 16'h8001;
    logic [7:0] i_acc = 8'h00;
    logic [15:0] i_word = 16'h0000;
    logic [15:0] o_addr;
    logic o_rw;
    logic [7:0] o_data_out;
    logic o_data_oe_n;
    logic o_sync;
    logic o_done;
    logic o_sp_dec2;
    logic [7:0] o_opcode;
    logic [15:0] o_operand;
    cbs_exp_s expq [$];
    cbs_exp_s e;
    logic oe;
    logic sync_pend;
    logic op_pend;
    logic [15:0] opv_pend;
    logic [7:0] op_now;
    logic [31:0] seed = 32'h41C7EAC5;
    logic [31:0] r;
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    cbs_sequencer u_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_mode(i_mode), .i_data_in(i_data_in),
        .i_int_data(i_int_data), .i_sp(i_sp), .i_acc(i_acc), .i_word(i_word),
        .o_addr(o_addr), .o_rw(o_rw), .o_data_out(o_data_out), .o_data_oe_n(o_data_oe_n),
        .o_sync(o_sync), .o_done(o_done), .o_sp_dec2(o_sp_dec2), .o_opcode(o_opcode),
        .o_operand(o_operand)
    );

    cbs_mem_model u_mem (
        .i_clk(i_clk), .i_addr(o_addr), .i_rw(o_rw), .i_wdata(o_data_out),
        .o_rdata(i_data_in), .o_int_data(i_int_data)
    );

    // Free-running core clock
    always #5 i_clk = ~i_clk;

    function automatic logic [31:0] xs_next();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic push(input logic [15:0] a, input logic rw, input logic [7:0] wd,
                        input logic done, input logic dec);
        expq.push_back('{a, rw, wd, done, sync_pend, dec, op_pend, opv_pend, op_now});
        sync_pend = 1'b0;
        op_pend = 1'b0;
    endtask

    // Lays a program into memory and notes every bus cycle it must produce.
    // Direct operands other than call targets stay in 80-FE so stores never overwrite code in 00-7F.
    task automatic build();
        logic [15:0] pc;
        logic [15:0] d;
        logic [15:0] ret;
        logic [7:0] b1;
        logic [3:0] cls;
        int i;
        pc = 16'h0000;
        i = 0;
        op_pend = 1'b0;
        while (pc < 16'h006A) begin
            r = xs_next();
            cls = (i < 16) ? 4'(i) : r[3:0];
            b1 = (cls > 4'h3 && cls < 4'hA) ? (8'h80 | r[15:8]) : r[15:8];
            if (b1 == 8'hFF) b1 = 8'hFE;
            ret = pc + 16'h2;
            if (cls == 4'h9) b1 = ret[7:0]; // Call lands on the next instruction
            d = {8'h00, b1};
            op_now = {cls, r[7:4]};
            u_mem.mem[pc] = op_now;
            u_mem.mem[pc + 16'h1] = b1;
            u_mem.mem[pc + 16'h2] = r[23:16];
            sync_pend = 1'b1;
            push(pc, 1'b1, 8'h00, cls == 4'h0 || cls > 4'h9, 1'b0);
            if (cls != 4'h0 && cls < 4'hA) begin
                push(pc + 16'h1, 1'b1, 8'h00, cls == 4'h1, 1'b0);
            end
            case (cls)
                4'h2, 4'h3: begin
                    push(pc + 16'h2, 1'b1, 8'h00, cls == 4'h2, 1'b0);
                    if (cls == 4'h3) push(cbs_pkg::VEC_ADDR, 1'b1, 8'h00, 1'b1, 1'b0);
                end
                4'h4, 4'h6, 4'h8: begin
                    push(d, 1'b1, 8'h00, cls == 4'h4, 1'b0);
                    if (cls != 4'h4) push(d + 16'h1, 1'b1, 8'h00, cls == 4'h6, 1'b0);
                    if (cls == 4'h8) push(cbs_pkg::VEC_ADDR, 1'b1, 8'h00, 1'b1, 1'b0);
                end
                4'h5: push(d, 1'b0, i_acc, 1'b1, 1'b0);
                4'h7: begin
                    push(d, 1'b0, i_word[15:8], 1'b0, 1'b0);
                    push(d + 16'h1, 1'b0, i_word[7:0], 1'b1, 1'b0);
                end
                4'h9: begin
                    push(d, 1'b1, 8'h00, 1'b0, 1'b0);
                    push(i_sp, 1'b0, ret[7:0], 1'b0, 1'b0);
                    push(i_sp - 16'h1, 1'b0, ret[15:8], 1'b1, 1'b1);
                end
                default: ;
            endcase
            if (cls == 4'h2) begin
                op_pend = 1'b1;
                opv_pend = {b1, r[23:16]};
            end
            if (cls == 4'h2 || cls == 4'h3) pc = pc + 16'h3;
            else if (cls == 4'h0 || cls > 4'h9) pc = pc + 16'h1;
            else pc = pc + 16'h2;
            i++;
        end
    endtask

    // Monitor: each finished bus cycle is held against the oldest note
    always @(posedge i_clk) begin
        if (i_rst_n && expq.size() > 0) begin
            e = expq.pop_front();
            check(o_addr, e.a);
            check({15'h0, o_rw}, {15'h0, e.rw});
            check({15'h0, o_sync}, {15'h0, e.sync});
            check({15'h0, o_done}, {15'h0, e.done});
            check({15'h0, o_sp_dec2}, {15'h0, e.dec});
            oe = e.rw ? !(i_mode == cbs_pkg::MODE_ZERO && e.a <= cbs_pkg::INT_TOP) : 1'b0;
            check({15'h0, o_data_oe_n}, {15'h0, oe});
            if (!e.rw) check({8'h00, o_data_out}, {8'h00, e.wd});
            else if (!oe) check({8'h00, o_data_out}, {8'h00, i_int_data});
            if (e.opc) check(o_operand, e.opv);
            if (!e.sync) check({8'h00, o_opcode}, {8'h00, e.op});
        end
    end

    // Hang guard, well above three programs of about 160 cycles each
    always @(posedge i_clk) begin
        cycles++;
        if (cycles >= 3000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Three programs, each after a fresh reset; the middle one in a non-zero mode
    initial begin
        for (int pass = 0; pass < 3; pass++) begin
            @(negedge i_clk);
            i_rst_n = 1'b0;
            r = xs_next();
            i_sp = {1'b1, r[14:1], 1'b1};
            i_acc = r[23:16];
            i_mode = (pass == 1) ? (r[26:24] | 3'h1) : cbs_pkg::MODE_ZERO;
            r = xs_next();
            i_word = r[15:0];
            build();
            repeat (10) @(negedge i_clk);
            i_rst_n = 1'b1;
            while (expq.size() != 0) @(negedge i_clk);
        end
        conclude();
    end
endmodule
